// ### include/ser_defs.svh
// Widths, field positions, valid masks, reset values and error codes for status reporting
`ifndef SER_DEFS_SVH
`define SER_DEFS_SVH
`define SER_OPER_W 16
`define SER_STD_W 8
`define SER_OPER_ENA_RST 16'h0000
`define SER_STD_ENA_RST 8'h00
`define SER_OPER_VALID 16'h0019
`define SER_STD_VALID 8'hBD
`define SER_COND_MEAS 4
`define SER_COND_SWEEP 3
`define SER_COND_CORR 0
`define SER_BIT_POWER_CYCLED 7
`define SER_BIT_USER_REQUEST 6
`define SER_BIT_COMMAND_ERROR 5
`define SER_BIT_EXECUTION_ERROR 4
`define SER_BIT_DEVICE_ERROR 3
`define SER_BIT_QUERY_ERROR 2
`define SER_BIT_REQUEST_CONTROL 1
`define SER_BIT_OPERATION_COMPLETE 0
`define SER_STB_OPER 7
`define SER_STB_STD 5
`define SER_STB_UNUSED 8'h5F
`define SER_ERR_CMD 16'hFF9C
`define SER_ERR_EXECUTION 16'hFF2D
`define SER_ERR_DEVICE 16'h000A
`define SER_ERR_QRY 16'hFE70
`endif

// ### include/ser_pkg.sv
// Types shared by the status reporting block
package ser_pkg;
  typedef struct packed {
    logic cmd_err;
    logic exec_err;
    logic dev_err;
    logic qry_err;
    logic op_done;
  } ser_evt_t;
  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } ser_err_t;
  typedef enum logic [1:0] {
    SER_CMD_NONE,
    SER_CMD_WR_OPER_ENA,
    SER_CMD_WR_STD_ENA,
    SER_CMD_RD
  } ser_cmd_t;
endpackage : ser_pkg

// ### sim/ser_host.sv
// Remote bus controller model issuing status commands
`timescale 1ns/1ps
`default_nettype none
module ser_host (
  input wire logic clk_i,
  output logic oper_wr_o,
  output logic std_wr_o,
  output logic [15:0] oper_data_o,
  output logic [7:0] std_data_o,
  output logic std_rd_o,
  output logic oper_rd_o,
  output ser_pkg::ser_evt_t evt_o
);
  initial begin
    {oper_wr_o, std_wr_o, std_rd_o, oper_rd_o, evt_o} = '0;
    oper_data_o = 16'h0000;
    std_data_o = 8'h00;
  end
  // One command per call; read target in d[0], 1 = standard
  task automatic cmd(input ser_pkg::ser_cmd_t c, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    oper_wr_o = (c == ser_pkg::SER_CMD_WR_OPER_ENA);
    std_wr_o = (c == ser_pkg::SER_CMD_WR_STD_ENA);
    std_rd_o = (c == ser_pkg::SER_CMD_RD) && d[0];
    oper_rd_o = (c == ser_pkg::SER_CMD_RD) && !d[0];
    oper_data_o = d;
    std_data_o = d[7:0];
    @(posedge clk_i);
    #1;
    {oper_wr_o, std_wr_o, std_rd_o, oper_rd_o} = 4'h0;
    oper_data_o = ~d;
    std_data_o = ~d[7:0];
  endtask : cmd
  // One-cycle event pulse
  task automatic evt(input ser_pkg::ser_evt_t e);
    @(posedge clk_i);
    #1;
    evt_o = e;
    @(posedge clk_i);
    #1;
    evt_o = '0;
  endtask : evt
endmodule : ser_host
`default_nettype wire

// ### sim/test_status_event_reporting.sv
// Self-checking bench for the status reporting block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end
module test_status_event_reporting;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic meas = 1'b0;
  logic sweep = 1'b0;
  logic corr = 1'b0;
  logic oper_wr, std_wr, std_rd, oper_rd;
  logic [15:0] oper_data, oper_rd_data, oper_ena, oper_cond;
  logic [7:0] std_data, std_rd_data, std_ena, stb;
  ser_pkg::ser_evt_t evt;
  ser_pkg::ser_err_t err;
  int mismatches = 0;
  int n_compared = 0;
  logic [15:0] codes [4] = '{16'hFF9C, 16'hFF2D, 16'h000A, 16'hFE70};
  always #4 clk = ~clk;
  ser_host i_host (.clk_i(clk), .oper_wr_o(oper_wr), .std_wr_o(std_wr),
    .oper_data_o(oper_data), .std_data_o(std_data), .std_rd_o(std_rd),
    .oper_rd_o(oper_rd), .evt_o(evt));
  ser_status i_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .MEAS_BUSY_I(meas),
    .SWEEP_BUSY_I(sweep), .CORR_BUSY_I(corr), .EVT_I(evt), .OPER_ENA_WR_I(oper_wr),
    .OPER_ENA_DATA_I(oper_data), .STD_ENA_WR_I(std_wr), .STD_ENA_DATA_I(std_data),
    .STD_RD_I(std_rd), .OPER_RD_I(oper_rd), .STD_RD_DATA_O(std_rd_data),
    .OPER_RD_DATA_O(oper_rd_data), .OPER_ENA_O(oper_ena), .STD_ENA_O(std_ena),
    .OPER_COND_O(oper_cond), .STB_O(stb), .ERR_PUSH_O(err));
  task automatic report_and_stop;
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic t_reset;
    `CHK(oper_ena, 16'h0000)
    `CHK(std_ena, 8'h00)
    i_host.cmd(ser_pkg::SER_CMD_RD, 16'h0001);
    `CHK(std_rd_data, 8'h80)
    i_host.cmd(ser_pkg::SER_CMD_RD, 16'h0001);
    `CHK(std_rd_data, 8'h00)
  endtask : t_reset
  task automatic t_std;
    i_host.cmd(ser_pkg::SER_CMD_WR_STD_ENA, 16'h00FF);
    `CHK(std_ena, 8'hFF)
    for (int i = 0; i < 4; i++) begin
      i_host.evt(5'h10 >> i);
      @(posedge clk);
      #1;
      `CHK(err, {1'b1, codes[i]})
      @(posedge clk);
      #1;
      `CHK(err.valid, 1'b0)
    end
    i_host.evt(5'h01);
    repeat (3) @(posedge clk);
    #1;
    `CHK(stb, 8'h20)
    i_host.cmd(ser_pkg::SER_CMD_RD, 16'h0001);
    `CHK(std_rd_data, 8'h3D)
    @(posedge clk);
    #1;
    `CHK(stb, 8'h00)
    i_host.cmd(ser_pkg::SER_CMD_WR_STD_ENA, 16'h0042);
    i_host.evt(5'h1F);
    repeat (4) @(posedge clk);
    #1;
    `CHK(stb, 8'h00)
    i_host.cmd(ser_pkg::SER_CMD_RD, 16'h0001);
    `CHK(std_rd_data, 8'h3D)
  endtask : t_std
  task automatic t_oper;
    i_host.cmd(ser_pkg::SER_CMD_WR_OPER_ENA, 16'hFFFF);
    `CHK(oper_ena, 16'hFFFF)
    meas = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK(oper_cond, 16'h0010)
    i_host.cmd(ser_pkg::SER_CMD_RD, 16'h0000);
    `CHK(oper_rd_data, 16'h0000)
    {meas, sweep, corr} = 3'h3;
    repeat (5) @(posedge clk);
    #1;
    `CHK(oper_cond, 16'h0009)
    {sweep, corr} = 2'h0;
    repeat (6) @(posedge clk);
    #1;
    `CHK(stb, 8'h80)
    i_host.cmd(ser_pkg::SER_CMD_RD, 16'h0000);
    `CHK(oper_rd_data, 16'h0019)
    @(posedge clk);
    #1;
    `CHK(stb, 8'h00)
  endtask : t_oper
  task automatic t_mid_reset;
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(oper_ena, 16'h0000)
    `CHK(std_ena, 8'h00)
    `CHK(std_rd_data, 8'h00)
    rst = 1'b0;
    i_host.cmd(ser_pkg::SER_CMD_RD, 16'h0001);
    `CHK(std_rd_data, 8'h80)
  endtask : t_mid_reset
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_std();
    t_oper();
    t_mid_reset();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule : test_status_event_reporting
`default_nettype wire

// ### src/ser_edge_det.sv
// Negative edge filter for the operation condition bits
`timescale 1ns/1ps
`default_nettype none
module ser_edge_det #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] cond_i,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] prev_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= cond_i;
    end
  end
  assign fall_o = prev_ff & ~cond_i;
endmodule : ser_edge_det
`default_nettype wire

// ### src/ser_err_code.sv
// Picks the error queue code for a new error event
`timescale 1ns/1ps
`default_nettype none
`include "ser_defs.svh"
module ser_err_code (
  input wire ser_pkg::ser_evt_t evt_i,
  output ser_pkg::ser_err_t err_o
);
  logic [15:0] code;
  always_comb begin
    code = 16'h0000;
    if (evt_i.cmd_err) begin
      code = `SER_ERR_CMD;
    end else if (evt_i.exec_err) begin
      code = `SER_ERR_EXECUTION;
    end else if (evt_i.dev_err) begin
      code = `SER_ERR_DEVICE;
    end else if (evt_i.qry_err) begin
      code = `SER_ERR_QRY;
    end
  end
  assign err_o = {evt_i.cmd_err | evt_i.exec_err | evt_i.dev_err | evt_i.qry_err, code};
endmodule : ser_err_code
`default_nettype wire

// ### src/ser_status.sv
// Status byte, operation and standard event registers
// How it works
// - 16-bit operation enable mask written by host
// - Stb bit 7 set by enabled operation events
// - Operation enable mask resets to zero
// - Operation event bits 1,2,5-15 read zero
// - Stb bit 5 set by enabled standard events
// - Error flags push numbered queue entries
// - Standard status read returns, clears, drops bit5
// - Bits 6 and 1 always read zero
// - Command error sets bit 5
// - Execution error sets bit 4
// - Device error sets bit 3
// - Query error sets bit 2
// - Operation complete sets bit 0
// - 8-bit standard enable mask written by host
// - Standard enable mask resets to zero
// - Operation events set on condition falling edge
// - Operation event read returns, clears, drops bit7
// - Condition bits 4,3,0 are measurement states
`timescale 1ns/1ps
`default_nettype none
`include "ser_defs.svh"
module ser_status (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic MEAS_BUSY_I,
  input wire logic SWEEP_BUSY_I,
  input wire logic CORR_BUSY_I,
  input wire ser_pkg::ser_evt_t EVT_I,
  input wire logic OPER_ENA_WR_I,
  input wire logic [15:0] OPER_ENA_DATA_I,
  input wire logic STD_ENA_WR_I,
  input wire logic [7:0] STD_ENA_DATA_I,
  input wire logic STD_RD_I,
  input wire logic OPER_RD_I,
  output logic [7:0] STD_RD_DATA_O,
  output logic [15:0] OPER_RD_DATA_O,
  output logic [15:0] OPER_ENA_O,
  output logic [7:0] STD_ENA_O,
  output logic [15:0] OPER_COND_O,
  output logic [7:0] STB_O,
  output ser_pkg::ser_err_t ERR_PUSH_O
);
  logic [2:0] meas_s1_ff, meas_s2_ff;
  logic [15:0] cond;
  logic [15:0] fall;
  logic [15:0] oper_evt_ff, nxt_oper_evt;
  logic [15:0] oper_ena_ff;
  logic [7:0] std_evt_ff, nxt_std_evt;
  logic [7:0] std_ena_ff;
  logic [7:0] std_set;
  logic power_cycled_flag_ff;
  logic oper_sum, std_sum;
  ser_pkg::ser_evt_t evt_ff;
  ser_pkg::ser_err_t err;

  // Synchronise status inputs from outside
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      meas_s1_ff <= 3'h0;
      meas_s2_ff <= 3'h0;
      evt_ff <= '0;
    end else begin
      meas_s1_ff <= {MEAS_BUSY_I, SWEEP_BUSY_I, CORR_BUSY_I};
      meas_s2_ff <= meas_s1_ff;
      evt_ff <= EVT_I;
    end
  end

  // Condition map
  assign cond = {11'h000, meas_s2_ff[2], meas_s2_ff[1], 2'h0, meas_s2_ff[0]};

  ser_edge_det #(.W(16)) u_edge (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .cond_i(cond),
    .fall_o(fall)
  );

  // Set wins over read-clear
  assign nxt_oper_evt = ((OPER_RD_I ? 16'h0000 : oper_evt_ff) | fall) & `SER_OPER_VALID;
  assign std_set[`SER_BIT_POWER_CYCLED] = power_cycled_flag_ff;
  assign std_set[`SER_BIT_USER_REQUEST] = 1'b0;
  assign std_set[`SER_BIT_COMMAND_ERROR] = evt_ff.cmd_err;
  assign std_set[`SER_BIT_EXECUTION_ERROR] = evt_ff.exec_err;
  assign std_set[`SER_BIT_DEVICE_ERROR] = evt_ff.dev_err;
  assign std_set[`SER_BIT_QUERY_ERROR] = evt_ff.qry_err;
  assign std_set[`SER_BIT_REQUEST_CONTROL] = 1'b0;
  assign std_set[`SER_BIT_OPERATION_COMPLETE] = evt_ff.op_done;
  assign nxt_std_evt = ((STD_RD_I ? 8'h00 : std_evt_ff) | std_set) & `SER_STD_VALID;
  assign oper_sum = |(nxt_oper_evt & oper_ena_ff);
  assign std_sum = |(nxt_std_evt & std_ena_ff);

  ser_err_code u_err (
    .evt_i(evt_ff),
    .err_o(err)
  );

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      oper_ena_ff <= `SER_OPER_ENA_RST;
      std_ena_ff <= `SER_STD_ENA_RST;
    end else begin
      if (OPER_ENA_WR_I) begin
        oper_ena_ff <= OPER_ENA_DATA_I;
      end
      if (STD_ENA_WR_I) begin
        std_ena_ff <= STD_ENA_DATA_I;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      oper_evt_ff <= 16'h0000;
      std_evt_ff <= 8'h00;
      power_cycled_flag_ff <= 1'b1;
      STB_O <= 8'h00;
      STD_RD_DATA_O <= 8'h00;
      OPER_RD_DATA_O <= 16'h0000;
      ERR_PUSH_O <= '0;
    end else begin
      oper_evt_ff <= nxt_oper_evt;
      std_evt_ff <= nxt_std_evt;
      power_cycled_flag_ff <= 1'b0;
      STB_O <= {oper_sum, 1'b0, std_sum, 5'h00};
      if (STD_RD_I) begin
        STD_RD_DATA_O <= std_evt_ff;
      end
      if (OPER_RD_I) begin
        OPER_RD_DATA_O <= oper_evt_ff;
      end
      ERR_PUSH_O <= err;
    end
  end

  assign OPER_ENA_O = oper_ena_ff;
  assign STD_ENA_O = std_ena_ff;
  assign OPER_COND_O = cond;

  property p_oper_sum;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    STB_O[`SER_STB_OPER] == |(oper_evt_ff & $past(oper_ena_ff));
  endproperty
  a_oper_sum: assert property (p_oper_sum) else $error("op summary wrong");
  property p_std_sum;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    STB_O[`SER_STB_STD] == |(std_evt_ff & $past(std_ena_ff));
  endproperty
  a_std_sum: assert property (p_std_sum) else $error("std summary wrong");
  property p_oper_zero;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (oper_evt_ff & ~`SER_OPER_VALID) == 16'h0000;
  endproperty
  a_oper_zero: assert property (p_oper_zero) else $error("reserved op bit set");
  property p_std_zero;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    std_evt_ff[6] == 1'b0 && std_evt_ff[1] == 1'b0;
  endproperty
  a_std_zero: assert property (p_std_zero) else $error("reserved std bit set");
  property p_std_rd;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    STD_RD_I && !evt_ff.cmd_err |=> STD_RD_DATA_O == $past(std_evt_ff) && !std_evt_ff[5];
  endproperty
  a_std_rd: assert property (p_std_rd) else $error("std read clear wrong");
  property p_oper_rd;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    OPER_RD_I && fall == 16'h0000 |=> oper_evt_ff == 16'h0000 && !STB_O[7];
  endproperty
  a_oper_rd: assert property (p_oper_rd) else $error("op read clear wrong");
  sequence s_meas_fall;
    meas_s2_ff[2] ##1 !meas_s2_ff[2];
  endsequence
  property p_fall;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    s_meas_fall |=> oper_evt_ff[4];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");
  property p_cmd_err;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    evt_ff.cmd_err |=> std_evt_ff[5] && ERR_PUSH_O.valid && ERR_PUSH_O.code == `SER_ERR_CMD;
  endproperty
  a_cmd_err: assert property (p_cmd_err) else $error("command error lost");
  property p_ena_wr;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    OPER_ENA_WR_I |=> OPER_ENA_O == $past(OPER_ENA_DATA_I);
  endproperty
  a_ena_wr: assert property (p_ena_wr) else $error("op mask write lost");
  property p_std_ena_wr;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    STD_ENA_WR_I |=> STD_ENA_O == $past(STD_ENA_DATA_I);
  endproperty
  a_std_ena_wr: assert property (p_std_ena_wr) else $error("std mask write lost");

  property p_oper_ena_rst;
    @(posedge REF_CLK_I)
    SYS_RST_I |=> OPER_ENA_O == `SER_OPER_ENA_RST;
  endproperty
  a_oper_ena_rst: assert property (p_oper_ena_rst) else $error("op mask not reset");
  property p_std_ena_rst;
    @(posedge REF_CLK_I)
    SYS_RST_I |=> STD_ENA_O == `SER_STD_ENA_RST;
  endproperty
  a_std_ena_rst: assert property (p_std_ena_rst) else $error("std mask not reset");
  sequence s_rst_release;
    SYS_RST_I ##1 !SYS_RST_I;
  endsequence
  property p_power_set;
    @(posedge REF_CLK_I)
    s_rst_release |=> std_evt_ff[`SER_BIT_POWER_CYCLED];
  endproperty
  a_power_set: assert property (p_power_set) else $error("power flag not set");
  property p_power_once;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    1'b1 |=> !power_cycled_flag_ff;
  endproperty
  a_power_once: assert property (p_power_once) else $error("power flag repeats");
  property p_exec_err;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    evt_ff.exec_err && !evt_ff.cmd_err |=> std_evt_ff[`SER_BIT_EXECUTION_ERROR] &&
      ERR_PUSH_O.valid && ERR_PUSH_O.code == `SER_ERR_EXECUTION;
  endproperty
  a_exec_err: assert property (p_exec_err) else $error("execution error lost");
  property p_dev_err;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    evt_ff.dev_err && !evt_ff.cmd_err && !evt_ff.exec_err |=> std_evt_ff[`SER_BIT_DEVICE_ERROR] &&
      ERR_PUSH_O.valid && ERR_PUSH_O.code == `SER_ERR_DEVICE;
  endproperty
  a_dev_err: assert property (p_dev_err) else $error("device error lost");
  property p_qry_err;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    evt_ff == 5'h02 |=> std_evt_ff[`SER_BIT_QUERY_ERROR] &&
      ERR_PUSH_O.valid && ERR_PUSH_O.code == `SER_ERR_QRY;
  endproperty
  a_qry_err: assert property (p_qry_err) else $error("query error lost");
  property p_no_err;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !(evt_ff.cmd_err | evt_ff.exec_err | evt_ff.dev_err | evt_ff.qry_err) |=>
      !ERR_PUSH_O.valid;
  endproperty
  a_no_err: assert property (p_no_err) else $error("spurious error push");
  property p_op_done;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    evt_ff.op_done |=> std_evt_ff[`SER_BIT_OPERATION_COMPLETE];
  endproperty
  a_op_done: assert property (p_op_done) else $error("completion flag lost");
  property p_std_keep;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !STD_RD_I |=> (std_evt_ff & $past(std_evt_ff)) == $past(std_evt_ff);
  endproperty
  a_std_keep: assert property (p_std_keep) else $error("std event lost");
  property p_oper_keep;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !OPER_RD_I |=> (oper_evt_ff & $past(oper_evt_ff)) == $past(oper_evt_ff);
  endproperty
  a_oper_keep: assert property (p_oper_keep) else $error("op event lost");
  property p_oper_quiet;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    $stable(cond) && !OPER_RD_I |=> $stable(oper_evt_ff);
  endproperty
  a_oper_quiet: assert property (p_oper_quiet) else $error("op event without edge");
  sequence s_meas_rise;
    !meas_s2_ff[2] ##1 meas_s2_ff[2];
  endsequence
  property p_meas_rise;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    s_meas_rise ##0 !oper_evt_ff[4] |=> !oper_evt_ff[4];
  endproperty
  a_meas_rise: assert property (p_meas_rise) else $error("rising edge counted");
  property p_cond_sync;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    1'b1 |=> ##1 OPER_COND_O[`SER_COND_MEAS] == $past(MEAS_BUSY_I, 2) &&
      OPER_COND_O[`SER_COND_SWEEP] == $past(SWEEP_BUSY_I, 2) &&
      OPER_COND_O[`SER_COND_CORR] == $past(CORR_BUSY_I, 2);
  endproperty
  a_cond_sync: assert property (p_cond_sync) else $error("condition map wrong");
  property p_cond_zero;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (OPER_COND_O & ~`SER_OPER_VALID) == 16'h0000;
  endproperty
  a_cond_zero: assert property (p_cond_zero) else $error("reserved cond bit set");
  property p_stb_unused;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (STB_O & `SER_STB_UNUSED) == 8'h00;
  endproperty
  a_stb_unused: assert property (p_stb_unused) else $error("unused stb bit set");
  property p_std_rd_stb;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    STD_RD_I && !(|evt_ff) && !power_cycled_flag_ff |=> !STB_O[`SER_STB_STD];
  endproperty
  a_std_rd_stb: assert property (p_std_rd_stb) else $error("std summary kept");
  property p_oper_rd_data;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    OPER_RD_I |=> OPER_RD_DATA_O == $past(oper_evt_ff);
  endproperty
  a_oper_rd_data: assert property (p_oper_rd_data) else $error("op read data wrong");
  property p_std_rd_hold;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !STD_RD_I |=> $stable(STD_RD_DATA_O);
  endproperty
  a_std_rd_hold: assert property (p_std_rd_hold) else $error("std read data moved");
  property p_oper_rd_hold;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !OPER_RD_I |=> $stable(OPER_RD_DATA_O);
  endproperty
  a_oper_rd_hold: assert property (p_oper_rd_hold) else $error("op read data moved");
  property p_oper_ena_hold;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !OPER_ENA_WR_I |=> $stable(OPER_ENA_O);
  endproperty
  a_oper_ena_hold: assert property (p_oper_ena_hold) else $error("op mask moved");
  property p_std_ena_hold;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !STD_ENA_WR_I |=> $stable(STD_ENA_O);
  endproperty
  a_std_ena_hold: assert property (p_std_ena_hold) else $error("std mask moved");
endmodule : ser_status
`default_nettype wire
